// [logic/sasr_reader.sv]
// Purpose: Serial converter readout: bit clock, frame pulse, capture
// Assumes: APB slave, pclk 200 MHz, all inputs synchronous to pclk
// Notes:   Samples land in a wrapping buffer read back over APB
module sasr_reader
    import sasr_pkg::*;
#(
    parameter int NBUF = BUF_DEPTH,
    parameter int NFIFO = FIFO_DEPTH
) (
    input  wire logic              pclk,                     // Clock
    input  wire logic              presetn,                  // Reset, low
    input  wire logic              ce,                       // Clock enable
    input  wire logic              psel,                     // APB select
    input  wire logic              penable,                  // APB enable
    input  wire logic              pwrite,                   // APB write
    input  wire logic [APB_AW-1:0] paddr,                    // APB address
    input  wire logic [APB_DW-1:0] pwdata,                   // APB wdata
    output logic      [APB_DW-1:0] prdata,                   // APB rdata
    output logic                   pready,                   // APB ready
    output logic                   pslverr,                  // APB error
    output logic                   tx_bit_clock_pin,         // Bit clock
    output logic                   tx_frame_pulse_pin,       // Frame pulse
    input  wire logic              receive_serial_input_pin, // Serial data
    output logic      [N_CS-1:0]   cs_n_pin                  // Selects, low
);
    localparam int IDX_W = $clog2(NBUF);
    localparam int LVL_W = $clog2(NFIFO) + 1;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NBUF - 1);
    localparam logic [FRAME_PERIOD_FIELD_W-1:0] BIT_LAST = FRAME_PERIOD_FIELD_W'(WORD_BITS - 1);
    function automatic logic hit(input logic go,
                                 input logic [APB_AW-1:0] a,
                                 input logic [APB_AW-1:0] off);
        return go && (a == off);
    endfunction
    // Control and configuration
    logic                 en_reg;
    logic                 multi_reg;
    logic                 hold_reg;
    logic [CSSEL_W-1:0]   cs_sel_reg;
    logic [DIV_W-1:0]     div_reg;
    logic [FRAME_PERIOD_FIELD_W-1:0]    frame_period_field_reg;
    logic [IDX_W-1:0]     rd_idx_reg;
    // Link side
    logic [DIV_W-1:0]     div_cnt_reg;
    logic [FRAME_PERIOD_FIELD_W-1:0]    frame_cnt_reg;
    logic                 sclk_reg;
    logic                 fs_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] word_reg;
    logic                 word_vld_reg;
    logic                 ovf_reg;
    logic [N_CS-1:0]      cs_n_reg;
    // Buffer side
    sasr_state_t          state_reg;
    logic [IDX_W-1:0]     wr_idx_reg;
    logic [WRAP_W-1:0]    wrap_cnt_reg;
    logic [WORD_BITS-1:0] buf_mem [NBUF];
    // APB
    logic [APB_DW-1:0]    prdata_reg;
    logic                 pready_reg;
    logic                 pslverr_reg;
    logic [APB_DW-1:0]    rdata_next;
    logic                 err_next;
    logic                 setup;
    logic                 wr_acc;
    logic [DIV_W-1:0]     half;
    logic                 period_end;
    logic                 rise_evt;
    logic                 frame_last;
    logic                 fifo_in_ready;
    logic                 fifo_out_valid;
    logic                 fifo_out_ready;
    logic [WORD_BITS-1:0] fifo_out_data;
    logic [LVL_W-1:0]     fifo_level;
    logic                 fifo_flush;
    logic                 pop;

    assign setup      = psel && !penable;
    assign wr_acc     = psel && penable && pwrite && !pslverr_reg;
    assign half       = div_reg >> 1;
    assign period_end = en_reg && (div_cnt_reg == div_reg - 8'h01);
    assign rise_evt   = en_reg && (div_cnt_reg == half - 8'h01);
    assign frame_last = frame_cnt_reg == frame_period_field_reg - 8'h01;
    always_comb begin
        rdata_next = ZERO_WORD;
        err_next   = 1'b0;
        case (paddr)
            OFF_CTRL: begin
                rdata_next[CTRL_EN_BIT]    = en_reg;
                rdata_next[CTRL_MULTI_BIT] = multi_reg;
                rdata_next[CTRL_HOLD_BIT]  = hold_reg;
                rdata_next[CTRL_CSSEL_LSB +: CSSEL_W] = cs_sel_reg;
            end
            OFF_DIV: begin
                rdata_next[DIV_W-1:0] = div_reg;
                err_next = pwrite && (en_reg ||
                           pwdata[DIV_W-1:0] < DIV_MIN);
            end
            OFF_FRAME_PERIOD_FIELD: begin
                rdata_next[FRAME_PERIOD_FIELD_W-1:0] = frame_period_field_reg;
                err_next = pwrite && (en_reg ||
                           pwdata[FRAME_PERIOD_FIELD_W-1:0] < FRAME_PERIOD_FIELD_MIN);
            end
            OFF_STAT: begin
                rdata_next[STAT_IDX_LSB +: IDX_W]   = wr_idx_reg;
                rdata_next[STAT_OVF_BIT]            = ovf_reg;
                rdata_next[STAT_LVL_LSB +: LVL_W]   = fifo_level;
                rdata_next[STAT_WRAP_LSB +: WRAP_W] = wrap_cnt_reg;
            end
            OFF_RIDX: rdata_next[IDX_W-1:0] = rd_idx_reg;
            OFF_RDAT: rdata_next[WORD_BITS-1:0] = buf_mem[rd_idx_reg];
            default:  err_next = 1'b1;
        endcase
    end

    // Answer is formed in setup so every access ends in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= ZERO_WORD;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg  <= setup;
            pslverr_reg <= setup && err_next;
            if (setup) begin
                prdata_reg <= pwrite ? ZERO_WORD : rdata_next;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg     <= 1'b0;
            multi_reg  <= 1'b0;
            hold_reg   <= 1'b0;
            cs_sel_reg <= '0;
            div_reg    <= DIV_RESET;
            frame_period_field_reg   <= FRAME_PERIOD_FIELD_RESET;
            rd_idx_reg <= '0;
        end else if (ce) begin
            if (hit(wr_acc, paddr, OFF_CTRL)) begin
                en_reg     <= pwdata[CTRL_EN_BIT];
                multi_reg  <= pwdata[CTRL_MULTI_BIT];
                hold_reg   <= pwdata[CTRL_HOLD_BIT];
                cs_sel_reg <= pwdata[CTRL_CSSEL_LSB +: CSSEL_W];
            end
            if (hit(wr_acc, paddr, OFF_DIV)) begin
                div_reg <= pwdata[DIV_W-1:0];
            end
            if (hit(wr_acc, paddr, OFF_FRAME_PERIOD_FIELD)) begin
                frame_period_field_reg <= pwdata[FRAME_PERIOD_FIELD_W-1:0];
            end
            if (hit(wr_acc, paddr, OFF_RIDX)) begin
                rd_idx_reg <= pwdata[IDX_W-1:0];
            end
        end
    end

    // Idle load makes the first enabled cycle a period end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_reg <= '0;
            sclk_reg    <= 1'b0;
        end else if (ce) begin
            if (!en_reg) begin
                div_cnt_reg <= div_reg - 8'h01;
                sclk_reg    <= 1'b0;
            end else if (period_end) begin
                div_cnt_reg <= '0;
                sclk_reg    <= 1'b0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
                if (rise_evt) begin
                    sclk_reg <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_cnt_reg <= '0;
            fs_reg        <= 1'b0;
        end else if (ce) begin
            if (!en_reg) begin
                frame_cnt_reg <= frame_period_field_reg - 8'h01;
                fs_reg        <= 1'b0;
            end else if (period_end) begin
                frame_cnt_reg <= frame_last ? '0 : frame_cnt_reg + 8'h01;
                fs_reg        <= frame_last;
            end
        end
    end

    // Data taken at the rising bit clock edge, MSB first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_reg    <= '0;
            word_reg     <= '0;
            word_vld_reg <= 1'b0;
        end else if (ce) begin
            word_vld_reg <= rise_evt && (frame_cnt_reg == BIT_LAST);
            if (rise_evt && frame_cnt_reg <= BIT_LAST) begin
                shift_reg <= {shift_reg[WORD_BITS-2:0],
                              receive_serial_input_pin};
            end
            if (rise_evt && frame_cnt_reg == BIT_LAST) begin
                word_reg <= {shift_reg[WORD_BITS-2:0],
                             receive_serial_input_pin};
            end
        end
    end

    // Set wins over the write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_reg <= 1'b0;
        end else if (ce) begin
            if (word_vld_reg && !fifo_in_ready) begin
                ovf_reg <= 1'b1;
            end else if (hit(wr_acc, paddr, OFF_STAT) &&
                         pwdata[STAT_OVF_BIT]) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_n_reg <= '1;
        end else if (ce) begin
            if (!multi_reg) begin
                cs_n_reg <= '0;
            end else begin
                cs_n_reg <= ~(N_CS'(en_reg) << cs_sel_reg);
            end
        end
    end

    assign fifo_flush     = state_reg != ST_RUN;
    assign fifo_out_ready = (state_reg == ST_RUN) && en_reg && !hold_reg;
    assign pop            = fifo_out_valid && fifo_out_ready;

    sasr_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (NFIFO)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .ce        (ce),
        .flush     (fifo_flush),
        .in_valid  (word_vld_reg),
        .in_ready  (fifo_in_ready),
        .in_data   (word_reg),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= ST_OFF;
            wr_idx_reg   <= '0;
            wrap_cnt_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                ST_OFF: begin
                    wr_idx_reg <= '0;
                    if (en_reg) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!en_reg) begin
                        state_reg <= ST_OFF;
                    end else if (pop && wr_idx_reg == IDX_LAST) begin
                        wr_idx_reg   <= '0;
                        wrap_cnt_reg <= wrap_cnt_reg + 8'h01;
                        state_reg    <= ST_FLUSH;
                    end else if (pop) begin
                        wr_idx_reg <= wr_idx_reg + 1'b1;
                    end
                end
                ST_FLUSH: begin
                    state_reg <= en_reg ? ST_RUN : ST_OFF;
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // Storage has no reset: contents are valid only once written
    always_ff @(posedge pclk) begin
        if (ce && pop) begin
            buf_mem[wr_idx_reg] <= fifo_out_data;
        end
    end

    // Single pulse pin feeds both read and conversion start
    assign tx_bit_clock_pin   = sclk_reg;
    assign tx_frame_pulse_pin = fs_reg;
    assign cs_n_pin           = cs_n_reg;
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;

    logic [DIV_W:0] gap_cnt_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt_reg <= '0;
        end else if (!en_reg || $changed(sclk_reg)) begin
            gap_cnt_reg <= '0;
        end else if (ce) begin
            gap_cnt_reg <= gap_cnt_reg + 1'b1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    clock_running_a: assert property (
        en_reg |-> gap_cnt_reg <= {1'b0, div_reg})
        else $error("bit clock stalled while enabled");
    rise_point_a: assert property (
        $rose(sclk_reg) |-> div_cnt_reg == half)
        else $error("bit clock rose at wrong divider count");
    frame_start_a: assert property (
        $rose(fs_reg) |-> frame_cnt_reg == '0 && !sclk_reg)
        else $error("frame pulse not at frame start");
    pulse_width_a: assert property (
        fs_reg && ce && period_end |=> !fs_reg)
        else $error("frame pulse wider than one bit period");
    word_done_a: assert property (
        ce && rise_evt && frame_cnt_reg == BIT_LAST
        |=> word_vld_reg && word_reg[0] == $past(receive_serial_input_pin))
        else $error("word not completed at twentieth bit");
    wrap_flush_a: assert property (
        ce && pop && wr_idx_reg == IDX_LAST
        |=> state_reg == ST_FLUSH && wr_idx_reg == '0 && fifo_flush)
        else $error("buffer wrap did not reset and flush");
    cfg_lock_a: assert property (
        ce && en_reg && psel && penable && pwrite && paddr == OFF_DIV
        |=> $stable(div_reg))
        else $error("divider changed while enabled");
    single_select_a: assert property (
        ce && !multi_reg |=> cs_n_pin == '0)
        else $error("select not held low in single mode");
    idle_quiet_a: assert property (
        !en_reg && $past(!en_reg) |-> !tx_frame_pulse_pin)
        else $error("frame pulse while disabled");
    frame_seen_c:  cover property ($rose(fs_reg));
    word_seen_c:   cover property (word_vld_reg && fifo_in_ready);
    wrap_seen_c:   cover property (state_reg == ST_FLUSH);
    overflow_c:    cover property ($rose(ovf_reg));
endmodule

// [logic/sasr_pkg.sv]
// Purpose: Shared constants for the serial converter sample reader
// Assumes: APB byte addressing, 32-bit data, one word per register
// Notes:   Defaults follow the documented sample-rate setup
package sasr_pkg;
    localparam int APB_AW     = 8;
    localparam int APB_DW     = 32;
    localparam int WORD_BITS  = 20;
    localparam int BUF_DEPTH  = 1024;
    localparam int FIFO_DEPTH = 16;
    localparam int N_CS       = 4;
    localparam int CSSEL_W    = 2;
    localparam int DIV_W      = 8;
    localparam int FRAME_PERIOD_FIELD_W     = 8;
    localparam int WRAP_W     = 8;

    localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFF_DIV  = 8'h04;
    localparam logic [APB_AW-1:0] OFF_FRAME_PERIOD_FIELD = 8'h08;
    localparam logic [APB_AW-1:0] OFF_STAT = 8'h0C;
    localparam logic [APB_AW-1:0] OFF_RIDX = 8'h10;
    localparam logic [APB_AW-1:0] OFF_RDAT = 8'h14;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_MULTI_BIT = 1;
    localparam int CTRL_HOLD_BIT  = 2;
    localparam int CTRL_CSSEL_LSB = 4;
    localparam int STAT_IDX_LSB   = 0;
    localparam int STAT_OVF_BIT   = 12;
    localparam int STAT_LVL_LSB   = 16;
    localparam int STAT_WRAP_LSB  = 24;

    localparam logic [DIV_W-1:0]  DIV_RESET  = 8'h10;
    localparam logic [DIV_W-1:0]  DIV_MIN    = 8'h02;
    localparam logic [FRAME_PERIOD_FIELD_W-1:0] FRAME_PERIOD_FIELD_RESET = 8'h14;
    localparam logic [FRAME_PERIOD_FIELD_W-1:0] FRAME_PERIOD_FIELD_MIN   = 8'h14;
    localparam logic [APB_DW-1:0] ZERO_WORD  = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_RUN   = 2'b01,
        ST_FLUSH = 2'b11
    } sasr_state_t;
endpackage

// [logic/sasr_fifo.sv]
// Purpose: Receive word FIFO between the serial shifter and the buffer
// Assumes: DEPTH is a power of two
// Notes:   Flush discards everything pending, push included
module sasr_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input  wire logic                     clk,       // Clock
    input  wire logic                     rst_n,     // Async reset, low
    input  wire logic                     ce,        // Clock enable
    input  wire logic                     flush,     // Drop contents
    input  wire logic                     in_valid,  // Push request
    output logic                          in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0]         in_data,   // Pushed word
    output logic                          out_valid, // Word available
    input  wire logic                     out_ready, // Pop request
    output logic [WIDTH-1:0]              out_data,  // Head word
    output logic [$clog2(DEPTH):0]        level      // Words held
);
    localparam int AW = $clog2(DEPTH);

    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign level     = wr_ptr_reg - rd_ptr_reg;
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (ce) begin
            if (flush) begin
                rd_ptr_reg <= wr_ptr_reg;
            end else begin
                if (push) begin
                    wr_ptr_reg <= wr_ptr_reg + 1'b1;
                end
                if (pop) begin
                    rd_ptr_reg <= rd_ptr_reg + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

// [testbench/sasr_conv_model.sv]
// Purpose: Converter model that shifts one known word per frame
// Assumes: Bit clock and frame pulse come from the reader
// Notes:   Line toggles while deselected or between words
module sasr_conv_model (
    input  wire logic pclk,  // Clock
    input  wire logic sclk,  // Bit clock in
    input  wire logic frame, // Read and start strobe
    input  wire logic cs_n,  // Select, low
    output logic      sdo    // Serial data out
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned frame_no = 0;
    logic [19:0] word     = 20'h0_0000;
    logic [4:0]  bitn     = 5'h14;
    logic        fr_q     = 1'b0;
    logic        ck_q     = 1'b0;
    logic        tog      = 1'b0;

    function automatic logic [19:0] wordf(input int unsigned n);
        return 20'(n * 32'h0000_9E37) ^ 20'hA_5C31;
    endfunction

    always @(posedge pclk) begin
        fr_q <= frame;
        ck_q <= sclk;
        tog  <= ~tog;
        if (frame && !fr_q) begin
            word     <= wordf(frame_no);
            frame_no <= frame_no + 1;
            bitn     <= 5'h00;
        end else if (ck_q && !sclk && bitn < 5'h14) begin
            bitn <= bitn + 5'h01;
        end
    end

    // Never a stale bit: a released line would hide a late sample
    assign sdo = (cs_n || bitn >= 5'h14) ? tog : word[5'h13 - bitn];
endmodule

// [testbench/test_serial_adc_sample_reader.sv]
// Purpose: Self-checking bench for the sample reader
// Assumes: Buffer shrunk to 16 entries to keep the run short
// Notes:   Divider and frame period are drawn at random
module test_serial_adc_sample_reader import sasr_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NB = 16;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [APB_AW-1:0] paddr   = 8'h00;
    logic [APB_DW-1:0] pwdata  = ZERO_WORD;
    logic [APB_DW-1:0] prdata;
    logic              pready, pslverr, sclk, fr, sdi;
    logic [N_CS-1:0]   cs_n;
    logic [31:0]       rd;
    logic              er;
    logic [7:0]        dv, fp;
    int unsigned       base;
    int                n_mismatch  = 0;
    int                checks_done = 0;

    sasr_reader #(.NBUF(NB), .NFIFO(FIFO_DEPTH)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_bit_clock_pin(sclk),
        .tx_frame_pulse_pin(fr), .receive_serial_input_pin(sdi),
        .cs_n_pin(cs_n));
    sasr_conv_model u_conv (
        .pclk(pclk), .sclk(sclk), .frame(fr), .cs_n(cs_n[0]), .sdo(sdi));

    initial forever #2.5 pclk = ~pclk;

    function automatic logic [19:0] wordf(input int unsigned n);
        return 20'(n * 32'h0000_9E37) ^ 20'hA_5C31;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One frame from the pulse rise: pulse width, low phase, rises
    task automatic frame_meas(input int d, input int f);
        int   hi, lo, rises;
        logic p;
        hi = 0;
        lo = -1;
        rises = 0;
        p = 1'b0;
        // Skip a pulse already under way, then catch a fresh rise
        while (fr === 1'b1) begin
            @(posedge pclk);
        end
        while (fr !== 1'b1) begin
            @(posedge pclk);
        end
        for (int i = 0; i < d * f; i++) begin
            hi += int'(fr === 1'b1);
            if (sclk === 1'b1 && p === 1'b0 && rises == 0) lo = i;
            rises += int'(sclk === 1'b1 && p === 1'b0);
            p = sclk;
            @(posedge pclk);
        end
        chk(32'(hi), 32'(d));
        chk(32'(lo), 32'(d / 2));
        chk(32'(rises), 32'(f));
        chk(32'(fr), 32'h0000_0001);
    endtask

    task automatic wrap_up();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h869178af));
        dv = 8'(4 + 2 * ($urandom % 3));
        fp = 8'(20 + $urandom % 5);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'(cs_n), 32'h0000_0000);
        chk(32'(sclk), 32'h0000_0000);
        apb(1'b0, OFF_DIV, ZERO_WORD);
        chk(rd, 32'(DIV_RESET));
        apb(1'b0, OFF_FRAME_PERIOD_FIELD, ZERO_WORD);
        chk(rd, 32'(FRAME_PERIOD_FIELD_RESET));
        apb(1'b0, 8'h3C, ZERO_WORD);
        chk(32'(er), 32'h0000_0001);
        apb(1'b1, OFF_DIV, 32'h0000_0001);
        chk(32'(er), 32'h0000_0001);
        apb(1'b1, OFF_FRAME_PERIOD_FIELD, 32'h0000_0013);
        chk(32'(er), 32'h0000_0001);
        apb(1'b1, OFF_DIV, 32'(dv));
        apb(1'b1, OFF_FRAME_PERIOD_FIELD, 32'(fp));
        chk(32'(er), 32'h0000_0000);
        $display("test config done");
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        base = u_conv.frame_no;
        apb(1'b1, OFF_DIV, 32'h0000_0008);
        chk(32'(er), 32'h0000_0001);
        frame_meas(int'(dv), int'(fp));
        $display("test timing done");
        do begin
            apb(1'b0, OFF_STAT, ZERO_WORD);
        end while (rd[31:24] === 8'h00);
        chk(32'(rd[31:24]), 32'h0000_0001);
        chk(32'(rd[9:0]), 32'h0000_0000);
        apb(1'b1, OFF_CTRL, ZERO_WORD);
        for (int i = 0; i < NB; i++) begin
            apb(1'b1, OFF_RIDX, 32'(i));
            apb(1'b0, OFF_RDAT, ZERO_WORD);
            chk(rd, 32'(wordf(base + i)));
        end
        $display("test capture done");
        apb(1'b1, OFF_CTRL, 32'h0000_0005);
        do begin
            apb(1'b0, OFF_STAT, ZERO_WORD);
        end while (rd[STAT_OVF_BIT] !== 1'b1);
        chk(32'(rd[20:16]), 32'(FIFO_DEPTH));
        apb(1'b1, OFF_CTRL, ZERO_WORD);
        apb(1'b1, OFF_STAT, 32'h0000_1000);
        apb(1'b0, OFF_STAT, ZERO_WORD);
        chk(32'({rd[20:12], rd[9:0]}), 32'h0000_0000);
        $display("test overflow done");
        apb(1'b1, OFF_CTRL, 32'h0000_0022);
        repeat (2) @(posedge pclk);
        chk(32'(cs_n), 32'h0000_000F);
        apb(1'b1, OFF_CTRL, 32'h0000_0023);
        repeat (2) @(posedge pclk);
        chk(32'(cs_n), 32'h0000_000B);
        apb(1'b1, OFF_CTRL, ZERO_WORD);
        $display("test select done");
        wrap_up();
    end
endmodule
